// File: pkg/wdst_pkg.sv
// Constants, register map and state types of the watchdog seed and self-test bank.
// Assumes a 32-bit classic Wishbone master and a 250 MHz system clock.
package wdst_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;
    localparam int RES_W = 15;
    localparam int IRQ_W = 4;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [ADR_W-1:0] OFS_SEED = 8'h00;
    localparam logic [ADR_W-1:0] OFS_RESP = 8'h04;
    localparam logic [ADR_W-1:0] OFS_GO = 8'h08;
    localparam logic [ADR_W-1:0] OFS_GO_INV = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_RESULT = 8'h10;
    localparam logic [ADR_W-1:0] OFS_MODE = 8'h14;
    localparam logic [ADR_W-1:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h1C;

    // ************************************************************
    // Reset values and forbidden seeds
    // ************************************************************
    localparam logic [REG_W-1:0] SEED_RST = 16'h5AB2;
    localparam logic [REG_W-1:0] SEED_ONES = 16'hFFFF;
    localparam logic [REG_W-1:0] SEED_ZEROS = 16'h0000;
    localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
    localparam logic [RES_W-1:0] RES_ZERO = 15'h0000;
    localparam logic [IRQ_W-1:0] IRQ_ZERO = 4'h0;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int GO_BIT = 0;
    localparam int MODE_INV_BIT = 0;
    localparam int BANDGAP_BIT = 14;
    localparam int RAIL2_UNDER_BIT = 13;
    localparam int RAIL2_OVER_BIT = 12;
    localparam int RAIL1_UNDER_BIT = 11;
    localparam int RAIL1_OVER_BIT = 10;
    localparam int EXTMON4_UNDER_BIT = 9;
    localparam int EXTMON4_OVER_BIT = 8;
    localparam int EXTMON3_UNDER_BIT = 7;
    localparam int EXTMON3_OVER_BIT = 6;
    localparam int EXTMON2_UNDER_BIT = 5;
    localparam int EXTMON2_OVER_BIT = 4;
    localparam int EXTMON1_UNDER_BIT = 3;
    localparam int EXTMON1_OVER_BIT = 2;
    localparam int OSC_BIT = 1;
    localparam int CRC_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_GOOD_BIT = 1;
    localparam int IRQ_BAD_BIT = 2;
    localparam int IRQ_REJ_BIT = 3;

    // ************************************************************
    // Self-test sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        BIST_IDLE = 2'b00,
        BIST_RUN = 2'b01,
        BIST_FINISH = 2'b10
    } wdst_bist_t;

endpackage

// File: sim/wdst_regs_tb.sv
// Self-checking bench of the watchdog seed and self-test register bank.
// Assumes wdst_regs is the top design module, run from a 250 MHz clock.
`timescale 1ns/1ps
module wdst_regs_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic done_i = 1'b0;
    logic [14:0] f = 15'h0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, irq_o, start_o, busy_o, good_o, bad_o;
    logic [15:0] seed_o;
    int n_errors = 0;
    int checked = 0;
    int n_start = 0;
    int n_good = 0;
    int n_bad = 0;

    wdst_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .selftest_start_o(start_o), .selftest_busy_o(busy_o), .wdog_seed_value_o(seed_o),
        .refresh_good_o(good_o), .refresh_bad_o(bad_o), .selftest_done_i(done_i),
        .bandgap_check_fail_i(f[14]), .rail2_under_check_fail_i(f[13]),
        .rail2_over_check_fail_i(f[12]), .rail1_under_check_fail_i(f[11]),
        .rail1_over_check_fail_i(f[10]), .extmon4_under_check_fail_i(f[9]),
        .extmon4_over_check_fail_i(f[8]), .extmon3_under_check_fail_i(f[7]),
        .extmon3_over_check_fail_i(f[6]), .extmon2_under_check_fail_i(f[5]),
        .extmon2_over_check_fail_i(f[4]), .extmon1_under_check_fail_i(f[3]),
        .extmon1_over_check_fail_i(f[2]), .oscillator_check_fail_i(f[1]),
        .fuse_crc_check_fail_i(f[0]));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (start_o === 1'b1) n_start++;
        if (good_o === 1'b1) n_good++;
        if (bad_o === 1'b1) n_bad++;
    end

    task automatic results;
        $display("counts: %0d checked, %0d errors", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Holds the request until ack is seen high at a rising edge, then releases it.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'h3;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask

    function automatic logic refused(input logic inv, input logic [15:0] v);
        return (v == 16'hFFFF) || (!inv && v == 16'h0000);
    endfunction

    initial begin
        #80000;
        n_errors++;
        results();
    end

    initial begin
        logic [15:0] seed, cand, resp;
        logic inv, rej, good;
        logic [31:0] q;
        int ng, nb, n;
        ng = 0;
        nb = 0;
        seed = 16'h5AB2;
        void'($urandom(29198));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(seed_o, 32'h5AB2, "seed port");
        rd(wdst_pkg::OFS_SEED, 32'h5AB2, "seed reset");
        rd(wdst_pkg::OFS_RESULT, 32'h0, "flags reset");
        rd(8'h40, 32'h0, "unmapped");
        wr(8'h40, 32'hFFFF);
        wr(wdst_pkg::OFS_IRQ_MASK, 32'hF);
        ce_i <= 1'b0;
        fork
            wr(wdst_pkg::OFS_SEED, 32'h1234);
            begin
                repeat (4) @(posedge clk_i);
                chk(wb_ack_o, 32'h0, "frozen ack");
                chk(seed_o, 32'h5AB2, "frozen seed");
                ce_i <= 1'b1;
            end
        join
        seed = 16'h1234;
        rd(wdst_pkg::OFS_SEED, 32'h1234, "seed after freeze");
        $display("test reset done");
        for (int i = 0; i < 30; i++) begin
            inv = i[0];
            cand = (i < 4) ? {16{i[1]}} : 16'($urandom);
            rej = refused(inv, cand);
            if (!rej) seed = cand;
            wr(wdst_pkg::OFS_MODE, {31'h0, inv});
            wr(wdst_pkg::OFS_SEED, {16'h0, cand});
            rd(wdst_pkg::OFS_SEED, {16'h0, seed}, "seed");
            chk(seed_o, {16'h0, seed}, "seed port");
            n = $urandom % 3;
            resp = (n == 0) ? seed : (n == 1) ? ~seed : 16'($urandom);
            good = inv ? (resp == ~seed) : (resp == seed);
            if (good) ng++;
            else nb++;
            wr(wdst_pkg::OFS_RESP, {16'h0, resp});
            rd(wdst_pkg::OFS_IRQ_STAT, {28'h0, rej, !good, good, 1'b0}, "status");
            wr(wdst_pkg::OFS_IRQ_STAT, 32'hF);
        end
        chk(n_good, ng, "good pulses");
        chk(n_bad, nb, "bad pulses");
        $display("test seed and refresh done");
        wr(wdst_pkg::OFS_GO_INV, 32'h1);
        wr(wdst_pkg::OFS_GO, 32'h1);
        rd(wdst_pkg::OFS_GO, 32'h0, "go gated");
        wr(wdst_pkg::OFS_GO_INV, 32'h0);
        wr(wdst_pkg::OFS_GO, 32'h0);
        chk(n_start, 0, "no start");
        for (int t = 0; t < 4; t++) begin
            f <= (t == 0) ? 15'h7FFF : (t == 1) ? 15'h0000 : 15'($urandom);
            wr(wdst_pkg::OFS_GO, 32'h1);
            rd(wdst_pkg::OFS_GO, 32'h1, "go busy");
            chk(busy_o, 32'h1, "busy");
            done_i <= 1'b1;
            n = 0;
            do begin bus(1'b0, wdst_pkg::OFS_GO, 32'h0, q); n++; end
            while (q[0] !== 1'b0 && n < 20);
            chk(q, 32'h0, "go self clear");
            rd(wdst_pkg::OFS_RESULT, {17'h0, f}, "flags");
            done_i <= 1'b0;
            rd(wdst_pkg::OFS_IRQ_STAT, 32'h1, "done status");
            if (t == 3) wr(wdst_pkg::OFS_IRQ_MASK, 32'h0);
            chk(irq_o, (t == 3) ? 32'h0 : 32'h1, "irq");
            wr(wdst_pkg::OFS_IRQ_STAT, 32'hF);
            chk(irq_o, 32'h0, "irq cleared");
        end
        chk(n_start, 4, "starts");
        $display("test self-test done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(seed_o, 32'h5AB2, "seed port after reset");
        rd(wdst_pkg::OFS_RESULT, 32'h0, "flags after reset");
        rd(wdst_pkg::OFS_SEED, 32'h5AB2, "seed after reset");
        $display("test mid-run reset done");
        results();
    end
endmodule

// File: verilog/wdst_regs.sv
// Watchdog seed and response registers with on-demand analog self-test control.
// Assumes analog check results are slow levels held stable while the done level is high.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

// Behaviour
// R1: The seed is a 16-bit register that resets to 16'h5AB2 in both answer modes.
// R2: In inverse-answer mode a seed write of all ones is dropped and the old seed stays.
// R3: In direct-answer mode a seed write of all zeros or all ones is dropped.
// R4: In direct-answer mode software refreshes by writing a response equal to the seed.
// R5: In inverse-answer mode software refreshes by writing the complement of the seed.
// R6: Writing 1 to the go bit starts a self-test only if the inverse bit holds 0.
// R7: The go bit clears itself when the self-test run ends and so reads as busy.
// R8: A result flag reads 1 for an error, 0 otherwise, and resets to 0.
// R9: The bandgap check failure sits in result bit 14.
// R10: Second converter rail under and over check failures sit in bits 13 and 12.
// R11: First converter rail under and over check failures sit in bits 11 and 10.
// R12: External monitors four down to one sit in pairs from bit 9 to 2, under high.
// R13: The oscillator check failure sits in bit 1.
// R14: The fuse CRC mismatch found by the self-test sits in bit 0.
// R15: All result flags update together at run end, before the go bit clears.
module wdst_regs (
    input wire logic clk_i, // System clock, 250 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable; freezes all state when low.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [wdst_pkg::ADR_W-1:0] wb_adr_i, // Wishbone byte address.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic [wdst_pkg::DAT_W-1:0] wb_dat_i, // Wishbone write data.
    output logic [wdst_pkg::DAT_W-1:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    output logic irq_o, // Interrupt, level, active high.
    output logic selftest_start_o, // One-cycle start pulse to the analog side.
    output logic selftest_busy_o, // Self-test running.
    output logic [wdst_pkg::REG_W-1:0] wdog_seed_value_o, // Current seed.
    output logic refresh_good_o, // One-cycle pulse: matching response written.
    output logic refresh_bad_o, // One-cycle pulse: wrong response written.
    input wire logic selftest_done_i, // Analog self-test finished, level.
    input wire logic bandgap_check_fail_i, // Bandgap check failed.
    input wire logic rail2_under_check_fail_i, // Rail 2 undervoltage check failed.
    input wire logic rail2_over_check_fail_i, // Rail 2 overvoltage check failed.
    input wire logic rail1_under_check_fail_i, // Rail 1 undervoltage check failed.
    input wire logic rail1_over_check_fail_i, // Rail 1 overvoltage check failed.
    input wire logic extmon4_under_check_fail_i, // Monitor 4 undervoltage check failed.
    input wire logic extmon4_over_check_fail_i, // Monitor 4 overvoltage check failed.
    input wire logic extmon3_under_check_fail_i, // Monitor 3 undervoltage check failed.
    input wire logic extmon3_over_check_fail_i, // Monitor 3 overvoltage check failed.
    input wire logic extmon2_under_check_fail_i, // Monitor 2 undervoltage check failed.
    input wire logic extmon2_over_check_fail_i, // Monitor 2 overvoltage check failed.
    input wire logic extmon1_under_check_fail_i, // Monitor 1 undervoltage check failed.
    input wire logic extmon1_over_check_fail_i, // Monitor 1 overvoltage check failed.
    input wire logic oscillator_check_fail_i, // Oscillator check failed.
    input wire logic fuse_crc_check_fail_i // Fuse CRC mismatch.
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic acc;
    logic wr;
    logic [wdst_pkg::DAT_W-1:0] rdata;
    logic [wdst_pkg::REG_W-1:0] seed_q;
    logic [wdst_pkg::REG_W-1:0] resp_q;
    logic [wdst_pkg::REG_W-1:0] seed_new;
    logic [wdst_pkg::REG_W-1:0] resp_new;
    logic seed_ok;
    logic mode_inv_q;
    logic go_inv_q;
    logic [wdst_pkg::RES_W-1:0] res_raw;
    logic [wdst_pkg::RES_W-1:0] res_sync;
    logic [wdst_pkg::RES_W-1:0] result_q;
    logic done_sync;
    logic done_prev_q;
    logic done_edge;
    logic go_set;
    wdst_pkg::wdst_bist_t bist_q;
    logic [wdst_pkg::IRQ_W-1:0] irq_stat_q;
    logic [wdst_pkg::IRQ_W-1:0] irq_mask_q;
    logic [wdst_pkg::IRQ_W-1:0] irq_ev;
    logic seed_wr;
    logic resp_wr;
    logic seed_rej;

    // ************************************************************
    // Bus slave and input synchroniser
    // ************************************************************
    wdst_wbif u_wbif (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .rdata_i(rdata),
        .acc_o(acc),
        .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o)
    );

    assign res_raw[wdst_pkg::BANDGAP_BIT] = bandgap_check_fail_i; // see R9
    assign res_raw[wdst_pkg::RAIL2_UNDER_BIT] = rail2_under_check_fail_i; // see R10
    assign res_raw[wdst_pkg::RAIL2_OVER_BIT] = rail2_over_check_fail_i; // see R10
    assign res_raw[wdst_pkg::RAIL1_UNDER_BIT] = rail1_under_check_fail_i; // see R11
    assign res_raw[wdst_pkg::RAIL1_OVER_BIT] = rail1_over_check_fail_i; // see R11
    assign res_raw[wdst_pkg::EXTMON4_UNDER_BIT] = extmon4_under_check_fail_i; // see R12
    assign res_raw[wdst_pkg::EXTMON4_OVER_BIT] = extmon4_over_check_fail_i; // see R12
    assign res_raw[wdst_pkg::EXTMON3_UNDER_BIT] = extmon3_under_check_fail_i; // see R12
    assign res_raw[wdst_pkg::EXTMON3_OVER_BIT] = extmon3_over_check_fail_i; // see R12
    assign res_raw[wdst_pkg::EXTMON2_UNDER_BIT] = extmon2_under_check_fail_i; // see R12
    assign res_raw[wdst_pkg::EXTMON2_OVER_BIT] = extmon2_over_check_fail_i; // see R12
    assign res_raw[wdst_pkg::EXTMON1_UNDER_BIT] = extmon1_under_check_fail_i; // see R12
    assign res_raw[wdst_pkg::EXTMON1_OVER_BIT] = extmon1_over_check_fail_i; // see R12
    assign res_raw[wdst_pkg::OSC_BIT] = oscillator_check_fail_i; // see R13
    assign res_raw[wdst_pkg::CRC_BIT] = fuse_crc_check_fail_i; // see R14

    wdst_sync #(
        .W(wdst_pkg::RES_W + 1)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i({selftest_done_i, res_raw}),
        .sync_o({done_sync, res_sync})
    );

    // ************************************************************
    // Write data merging and decode
    // ************************************************************
    assign wr = acc && wb_we_i;
    assign seed_new = {wb_sel_i[1] ? wb_dat_i[15:8] : seed_q[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : seed_q[7:0]};
    assign resp_new = {wb_sel_i[1] ? wb_dat_i[15:8] : resp_q[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : resp_q[7:0]};
    assign seed_wr = wr && (wb_adr_i == wdst_pkg::OFS_SEED) && (wb_sel_i[1:0] != 2'h0);
    assign resp_wr = wr && (wb_adr_i == wdst_pkg::OFS_RESP) && (wb_sel_i[1:0] != 2'h0);
    // All ones is refused in both modes; all zeros only in direct-answer mode.
    assign seed_ok = (seed_new != wdst_pkg::SEED_ONES) // see R2
                     && (mode_inv_q || seed_new != wdst_pkg::SEED_ZEROS); // see R3
    assign seed_rej = seed_wr && !seed_ok;

    // ************************************************************
    // Watchdog seed and response
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seed_q <= wdst_pkg::SEED_RST; // see R1
        end else if (ce_i && seed_wr && seed_ok) begin
            seed_q <= seed_new; // see R2 R3
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resp_q <= wdst_pkg::REG_ZERO;
        end else if (ce_i && resp_wr) begin
            resp_q <= resp_new;
        end
    end

    // The response is judged against the seed in force at the write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            refresh_good_o <= 1'b0;
            refresh_bad_o <= 1'b0;
        end else if (ce_i) begin
            refresh_good_o <= resp_wr && (resp_new == (mode_inv_q ? ~seed_q : seed_q)); // see R4 R5
            refresh_bad_o <= resp_wr && (resp_new != (mode_inv_q ? ~seed_q : seed_q)); // see R4 R5
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdog_seed_value_o <= wdst_pkg::SEED_RST;
        end else if (ce_i) begin
            wdog_seed_value_o <= seed_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_inv_q <= 1'b0;
        end else if (ce_i && wr && wb_adr_i == wdst_pkg::OFS_MODE && wb_sel_i[0]) begin
            mode_inv_q <= wb_dat_i[wdst_pkg::MODE_INV_BIT];
        end
    end

    // ************************************************************
    // On-demand self-test sequencer
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            go_inv_q <= 1'b0;
        end else if (ce_i && wr && wb_adr_i == wdst_pkg::OFS_GO_INV && wb_sel_i[0]) begin
            go_inv_q <= wb_dat_i[wdst_pkg::GO_BIT];
        end
    end

    assign go_set = wr && wb_adr_i == wdst_pkg::OFS_GO && wb_sel_i[0]
                    && wb_dat_i[wdst_pkg::GO_BIT] && !go_inv_q; // see R6
    assign done_edge = done_sync && !done_prev_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_prev_q <= 1'b0;
        end else if (ce_i) begin
            done_prev_q <= done_sync;
        end
    end

    // A go write while a run is active is ignored; a done seen while idle is ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bist_q <= wdst_pkg::BIST_IDLE;
        end else if (ce_i) begin
            unique case (bist_q)
                wdst_pkg::BIST_IDLE: begin
                    if (go_set) begin
                        bist_q <= wdst_pkg::BIST_RUN; // see R6
                    end
                end
                wdst_pkg::BIST_RUN: begin
                    if (done_edge) begin
                        bist_q <= wdst_pkg::BIST_FINISH; // see R15
                    end
                end
                wdst_pkg::BIST_FINISH: begin
                    bist_q <= wdst_pkg::BIST_IDLE; // see R7
                end
                default: begin
                    bist_q <= wdst_pkg::BIST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            selftest_start_o <= 1'b0;
            selftest_busy_o <= 1'b0;
        end else if (ce_i) begin
            selftest_start_o <= (bist_q == wdst_pkg::BIST_IDLE) && go_set;
            selftest_busy_o <= (bist_q != wdst_pkg::BIST_IDLE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= wdst_pkg::RES_ZERO; // see R8
        end else if (ce_i && bist_q == wdst_pkg::BIST_RUN && done_edge) begin
            result_q <= res_sync; // see R15
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irq_ev[wdst_pkg::IRQ_DONE_BIT] = (bist_q == wdst_pkg::BIST_FINISH);
    assign irq_ev[wdst_pkg::IRQ_GOOD_BIT] = refresh_good_o;
    assign irq_ev[wdst_pkg::IRQ_BAD_BIT] = refresh_bad_o;
    assign irq_ev[wdst_pkg::IRQ_REJ_BIT] = seed_rej;

    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= wdst_pkg::IRQ_ZERO;
        end else if (ce_i) begin
            if (wr && wb_adr_i == wdst_pkg::OFS_IRQ_STAT && wb_sel_i[0]) begin
                irq_stat_q <= (irq_stat_q & ~wb_dat_i[wdst_pkg::IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= wdst_pkg::IRQ_ZERO;
        end else if (ce_i && wr && wb_adr_i == wdst_pkg::OFS_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_q <= wb_dat_i[wdst_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    always_comb begin
        rdata = '0;
        unique case (wb_adr_i)
            wdst_pkg::OFS_SEED: rdata[wdst_pkg::REG_W-1:0] = seed_q;
            wdst_pkg::OFS_RESP: rdata[wdst_pkg::REG_W-1:0] = resp_q;
            wdst_pkg::OFS_GO: rdata[wdst_pkg::GO_BIT] = (bist_q != wdst_pkg::BIST_IDLE); // see R7
            wdst_pkg::OFS_GO_INV: rdata[wdst_pkg::GO_BIT] = go_inv_q;
            wdst_pkg::OFS_RESULT: rdata[wdst_pkg::RES_W-1:0] = result_q; // see R9 R14
            wdst_pkg::OFS_MODE: rdata[wdst_pkg::MODE_INV_BIT] = mode_inv_q;
            wdst_pkg::OFS_IRQ_STAT: rdata[wdst_pkg::IRQ_W-1:0] = irq_stat_q;
            wdst_pkg::OFS_IRQ_MASK: rdata[wdst_pkg::IRQ_W-1:0] = irq_mask_q;
            default: rdata = '0;
        endcase
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_seed_reset_value: assert property ($past(rst_i) |-> seed_q == wdst_pkg::SEED_RST) // see R1
        else $error("seed not at reset value after reset");
    a_seed_inv_ones: assert property (seed_wr && mode_inv_q // see R2
        && seed_new == wdst_pkg::SEED_ONES |=> $stable(seed_q))
        else $error("all-ones seed accepted in inverse mode");
    a_seed_dir_reject: assert property (seed_wr && !mode_inv_q // see R3
        && (seed_new == wdst_pkg::SEED_ZEROS || seed_new == wdst_pkg::SEED_ONES)
        |=> $stable(seed_q))
        else $error("forbidden seed accepted in direct mode");
    a_go_start_run: assert property (go_set && bist_q == wdst_pkg::BIST_IDLE // see R6
        |=> selftest_start_o ##1 (selftest_busy_o || !ce_i))
        else $error("valid go write did not start self-test");
    a_go_blocked: assert property (wr && wb_adr_i == wdst_pkg::OFS_GO // see R6
        && bist_q == wdst_pkg::BIST_IDLE
        && (go_inv_q || !wb_dat_i[wdst_pkg::GO_BIT]) |=> !selftest_start_o)
        else $error("self-test started without valid go write");
    a_go_self_clear: assert property (ce_i && bist_q == wdst_pkg::BIST_FINISH
        |=> bist_q == wdst_pkg::BIST_IDLE) // see R7
        else $error("go bit did not clear after run end");
    a_flags_reset: assert property ($past(rst_i) |-> result_q == wdst_pkg::RES_ZERO) // see R8
        else $error("result flags not cleared by reset");
    a_flags_latch_order: assert property (ce_i && bist_q == wdst_pkg::BIST_RUN // see R15
        && done_edge |=> result_q == $past(res_sync) && bist_q == wdst_pkg::BIST_FINISH)
        else $error("results not latched before go cleared");
    a_status_read_map: assert property (acc && !wb_we_i // see R9 R10 R11 R12 R13 R14
        && wb_adr_i == wdst_pkg::OFS_RESULT
        |=> wb_dat_o == {17'h00000, $past(result_q)})
        else $error("result register read mismatch");

    c_selftest_start: cover property (selftest_start_o);
    c_selftest_done: cover property (bist_q == wdst_pkg::BIST_FINISH);
    c_seed_rejected: cover property (seed_rej);
    c_refresh_good: cover property (refresh_good_o);

endmodule

// File: verilog/wdst_sync.sv
// Two-stage synchroniser for a vector of unrelated level inputs.
// Assumes each bit is a slow level from the analog side; no word coherency is given.
`timescale 1ns/1ps
module wdst_sync #(
    parameter int W = 16
) (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable.
    input wire logic [W-1:0] async_i, // Asynchronous levels.
    output logic [W-1:0] sync_o // Synchronised levels.
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// File: verilog/wdst_wbif.sv
// Classic Wishbone slave handshake: one access strobe, registered ack and read data.
// Assumes a single-cycle classic master that holds the request until ack.
`timescale 1ns/1ps
module wdst_wbif (
    input wire logic clk_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic [wdst_pkg::DAT_W-1:0] rdata_i, // Read data of the addressed register.
    output logic acc_o, // One-cycle access strobe.
    output logic wb_ack_o, // Acknowledge.
    output logic [wdst_pkg::DAT_W-1:0] wb_dat_o // Read data.
);

    assign acc_o = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= acc_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (acc_o) begin
            wb_dat_o <= rdata_i;
        end
    end

endmodule
